// file: dv/host_model.sv
`timescale 1ns/100ps

module host_model (
    // Clock
    input  wire logic              sys_clk_i,
    // Traffic toward the port
    output hs_test_pkg::test_req_t req_o,
    output hs_test_pkg::token_t    tok_o,
    output hs_test_pkg::wire_bit_t rx_o
);
    // Quiet bus at time zero
    initial begin
        req_o = '0;
        tok_o = '0;
        rx_o  = '0;
    end
    // Token CRC, address bits first, low bit first
    function automatic logic [4:0] crc5(input logic [10:0] d);
        logic [4:0] c;
        c = 5'h1F;
        for (int i = 0; i < 11; i++)
            c = (d[i] ^ c[4]) ? ({c[3:0], 1'b0} ^ 5'h05) : {c[3:0], 1'b0};
        return ~c;
    endfunction : crc5
    task automatic request(input logic port, input logic [7:0] sel);
        @(negedge sys_clk_i) req_o = {1'b1, port, sel};
        @(negedge sys_clk_i) req_o = '0;
    endtask : request
    task automatic token(input logic [7:0] pid, input logic bad);
        @(negedge sys_clk_i) tok_o = {1'b1, pid, 7'h2A, 4'h3, crc5({4'h3, 7'h2A}) ^ {4'h0, bad}};
        @(negedge sys_clk_i) tok_o = '0;
    endtask : token
    // received bit; idle line shows no stale value
    task automatic rx_bit(input logic a, input logic d);
        @(negedge sys_clk_i) rx_o = {a, a ? d : ~rx_o.data};
    endtask : rx_bit
endmodule : host_model

// file: dv/tb.sv
`timescale 1ns/100ps
`include "hs_test_regs.svh"

module tb;
    logic                   sys_clk_i, rst_b_i, hs_cap, up_port, disc, hub_rst, line_act, await_r;
    logic                   ack, stall, ready, pen, disc_st, tmo, reply, txe;
    logic [7:0]             mode;
    hs_test_pkg::test_req_t req;
    hs_test_pkg::token_t    tok;
    hs_test_pkg::wire_bit_t rx;
    hs_test_pkg::line_drv_t line;
    int                     fail_count, compares;

    assign txe = line.tx_en;
    host_model host (.sys_clk_i(sys_clk_i), .req_o(req), .tok_o(tok), .rx_o(rx));
    hs_test_mode_ctrl #(.ENTRY_MAX_CYC(100)) dut (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .hs_capable_i(hs_cap), .upstream_port_i(up_port),
        .disc_det_i(disc), .req_i(req), .hub_reset_i(hub_rst), .token_i(tok), .up_rx_i(rx),
        .line_active_i(line_act), .await_rsp_i(await_r), .req_ack_o(ack), .req_stall_o(stall),
        .mode_o(mode), .mode_ready_o(ready), .line_o(line), .port_enable_o(pen),
        .disc_status_o(disc_st), .rsp_timeout_o(tmo), .rsp_reply_o(reply));

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // Power cycle; straps are caught once after release
    task automatic power(input logic cap, input logic up);
        @(negedge sys_clk_i) rst_b_i = 1'b0;
        hs_cap = cap;
        up_port = up;
        repeat (16) @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        repeat (8) @(negedge sys_clk_i);
    endtask : power
    task automatic enter(input logic port, input logic [7:0] sel, input logic ok);
        host.request(port, sel);
        // The answer stands only until the edge after the accepting one
        chk("ack", ack, ok);
        chk("stall", stall, !ok);
        @(posedge sys_clk_i) #1;
        if (ok) chk("mode", mode, sel);
        repeat (8) @(posedge sys_clk_i);
        #1;
        if (ok) chk("ready", ready, 1'b1);
    endtask : enter
    task automatic t_jk();
        power(1'b0, 1'b1);
        enter(1'b0, 8'h01, 1'b0);
        power(1'b1, 1'b1);
        enter(1'b1, 8'h01, 1'b0);
        enter(1'b0, 8'h05, 1'b0);
        enter(1'b0, 8'h01, 1'b1);
        enter(1'b0, 8'h02, 1'b0);
        @(negedge sys_clk_i) hub_rst = 1'b1;
        repeat (40) @(negedge sys_clk_i);
        hub_rst = 1'b0;
        chk("mode_up", mode, 8'h01);
        chk("line_j", {line.drive_j, line.drive_k, txe}, 3'b100);
        power(1'b1, 1'b1);
        enter(1'b0, 8'h02, 1'b1);
        chk("line_k", {line.drive_j, line.drive_k, txe}, 3'b010);
    endtask : t_jk
    task automatic nak(input logic [7:0] pid, input logic bad, input logic exp);
        logic [47:0] w;
        int          k;
        host.token(pid, bad);
        k = 0;
        while (txe !== 1'b1 && k < 8) begin
            @(posedge sys_clk_i) #1;
            k++;
        end
        chk("nak_seen", txe === 1'b1, exp);
        if (exp) begin
            chk("nak_gap", k >= 1 && k <= 4, 1'b1);
            for (int i = 0; i < 48; i++) begin
                w = {w[46:0], line.tx_bit};
                @(posedge sys_clk_i) #1;
            end
            chk("nak_bits", w, `NAK_PKT_WIRE);
            chk("nak_end", txe, 1'b0);
        end
    endtask : nak
    task automatic t_nak();
        power(1'b1, 1'b1);
        enter(1'b0, 8'h03, 1'b1);
        chk("hs_rx", line.hs_rx, 1'b1);
        nak(8'h69, 1'b1, 1'b0);
        nak(8'hE1, 1'b0, 1'b0);
        nak(8'h69, 1'b0, 1'b1);
        nak(8'h69, 1'b0, 1'b1);
    endtask : t_nak
    task automatic t_pkt();
        logic [47:0] head;
        logic [23:0] tail;
        logic [15:0] mid;
        int          n, k;
        power(1'b1, 1'b1);
        enter(1'b0, 8'h04, 1'b1);
        for (int p = 0; p < 3; p++) begin
            k = 0;
            while (txe !== 1'b1 && k < 1300) begin
                @(posedge sys_clk_i) #1;
                k++;
            end
            if (p == 2) chk("gap", k, `PKT_GAP_CYC);
            n = 0;
            while (p > 0 && txe === 1'b1 && n < 600) begin
                if (n < 48) head = {head[46:0], line.tx_bit};
                if (n >= 168 && n < 184) mid = {mid[14:0], line.tx_bit};
                tail = {tail[22:0], line.tx_bit};
                n++;
                @(posedge sys_clk_i) #1;
            end
            if (p == 0) continue;
            chk("pkt_len", n, 522);
            chk("pkt_head", head, 48'h00000001C300);
            chk("pkt_mid", mid, 16'h5577);
            chk("pkt_tail", tail, 24'h6D737F);
        end
    endtask : t_pkt
    task automatic t_force();
        power(1'b1, 1'b0);
        enter(1'b0, 8'h01, 1'b0);
        enter(1'b1, 8'h05, 1'b1);
        chk("pen", pen, 1'b1);
        for (int i = 0; i < 4; i++) begin
            host.rx_bit(1'b1, i[0] ^ i[1]);
            @(posedge sys_clk_i) #1;
            chk("repeat", {txe, line.tx_bit}, {1'b1, i[0] ^ i[1]});
        end
        host.rx_bit(1'b0, 1'b0);
        for (int i = 0; i < 2; i++) begin
            @(negedge sys_clk_i) disc = !i[0];
            repeat (4) @(negedge sys_clk_i);
            chk("disc", disc_st, !i[0]);
        end
        @(negedge sys_clk_i) hub_rst = 1'b1;
        @(negedge sys_clk_i) hub_rst = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk("exit", {mode, pen}, 9'h000);
        // A downstream port in receive-only mode must stay silent on tokens
        enter(1'b1, 8'h03, 1'b1);
        nak(8'h69, 1'b0, 1'b0);
    endtask : t_force
    task automatic t_rsp(input int late);
        int k, seen;
        @(negedge sys_clk_i) await_r = 1'b1;
        @(negedge sys_clk_i) await_r = 1'b0;
        seen = 0;
        for (k = 1; k < 25; k++) begin
            if (k == late) line_act = 1'b1;
            @(posedge sys_clk_i) #1;
            if (tmo === 1'b1) seen = k;
            if (reply === 1'b1) seen = 100 + k;
            @(negedge sys_clk_i);
        end
        line_act = 1'b0;
        chk("rsp", seen, late > 0 ? 100 + late : `RSP_ABANDON_CYC);
    endtask : t_rsp

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // Limit set well above the roughly 1600 cycles that the scenarios need
    initial begin
        #(100 * 20000);
        fail_count++;
        conclude();
    end
    initial begin
        {rst_b_i, hs_cap, up_port, disc, hub_rst, line_act, await_r} = 7'h00;
        fail_count = 0;
        compares = 0;
        t_jk();
        t_nak();
        t_pkt();
        t_force();
        t_rsp(0);
        t_rsp(10);
        conclude();
    end
endmodule : tb

// file: inc/hs_test_pkg.sv
package hs_test_pkg;

    // Entry request, presented when the status stage completes
    typedef struct packed {
        logic       valid;
        logic       port_req;   // 1: hub port request, 0: device request
        logic [7:0] selector;
    } test_req_t;

    // Token decoded by the packet receiver
    typedef struct packed {
        logic       valid;
        logic [7:0] pid;
        logic [6:0] addr;
        logic [3:0] endp;
        logic [4:0] crc5;       // Bit 4 was first on the wire
    } token_t;

    // One wire bit of a packet, NRZ
    typedef struct packed {
        logic active;
        logic data;
    } wire_bit_t;

    // Commands to the high-speed transceiver
    typedef struct packed {
        logic hs_rx;
        logic drive_j;
        logic drive_k;
        logic tx_en;
        logic tx_bit;
    } line_drv_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SETTLE = 3'b010,
        ST_ACTIVE = 3'b100
    } mode_state_t;

endpackage : hs_test_pkg

// file: inc/hs_test_regs.svh
`ifndef HS_TEST_REGS_SVH
`define HS_TEST_REGS_SVH

// Clock and link rates used to turn bit times into clock cycles
`define CLK_MHZ          10
`define HS_MBPS          480

// Response window, in high-speed bit times
`define RSP_KEEP_BT      736
`define RSP_ABANDON_BT   816
`define RSP_KEEP_CYC     ((`RSP_KEEP_BT * `CLK_MHZ + `HS_MBPS - 1) / `HS_MBPS)
`define RSP_ABANDON_CYC  ((`RSP_ABANDON_BT * `CLK_MHZ) / `HS_MBPS)

// Inter-packet gaps, in bit times
`define RSP_MAX_IPG_BT   192
`define RSP_MAX_IPG_CYC  ((`RSP_MAX_IPG_BT * `CLK_MHZ) / `HS_MBPS)
`define MIN_IPG_BT       8
`define MIN_IPG_CYC      ((`MIN_IPG_BT * `CLK_MHZ + `HS_MBPS - 1) / `HS_MBPS)

// Gap between repeated test packets
`define PKT_GAP_MAX_US   125
`define PKT_GAP_MAX_CYC  (`PKT_GAP_MAX_US * `CLK_MHZ)
`define PKT_GAP_CYC      16

// Entry into a test mode
`define ENTRY_MAX_US     3000
`define ENTRY_MAX_CYC    (`ENTRY_MAX_US * `CLK_MHZ)
`define SETTLE_CYC       8

// Test selectors carried by the entry requests
`define SEL_NONE         8'h00
`define SEL_TEST_J       8'h01
`define SEL_TEST_K       8'h02
`define SEL_SE0_NAK      8'h03
`define SEL_PACKET       8'h04
`define SEL_FORCE_EN     8'h05

// Token and handshake encodings
`define PID_IN           8'h69
`define NAK_PKT_BITS     48
`define NAK_PKT_WIRE     48'h000000015A7F
`define TEST_PKT_BITS    522

`endif

// file: verilog/hs_test_mode_ctrl.sv
`timescale 1ns/100ps
`include "hs_test_regs.svh"

// Summary of operation
// - An awaited reply may take 736 bit times; abandon after 816 bit times.
// - Receive-only NAK mode holds the transceiver in high-speed receive until exit.
// - Upstream port in that mode NAKs each IN token with a good CRC that arrives while no NAK is in flight.
// - Constant-J mode drives high-speed J from entry until exit.
// - Constant-K mode drives high-speed K from entry until exit.
// - Packet mode sends the test packet over and over until exit.
// - Packet opens with 32-bit sync ending in one, then DATA0 PID.
// - Then nine zero bytes, eight 0x55 bytes, eight 0x77 bytes.
// - Then 0, fifteen six-ones-plus-stuff groups, six ones: 97 data bits.
// - Then 55 data bits of stuff, ones and seven 0111111 groups.
// - Then 00111111, nine stuff-plus-0111111 groups, stuff and 0: 72 bits.
// - Leftmost bit first; fixed CRC16 and EOP close the packet.
// - Gap between test packets lies between minimum gap and 125 us.
// - Forced enable applies to downstream hub ports only, device or not.
// - Forced-enable port repeats every packet from the upstream port.
// - Disconnect detect stays live and readable while force-enabled.
// - Device request enters upstream port modes, hub port request downstream.
// - A port that is not high-speed capable refuses both entry requests.
// - The requested mode is fully in force within 3 ms of status stage.
// - Upstream exit is power cycle only; downstream exit is hub reset.
// - The NAK reply starts within 192 bit times of the token.
// - The NAK reply leaves at least 8 bit times after the token.
module hs_test_mode_ctrl #(
    parameter int ENTRY_MAX_CYC = `ENTRY_MAX_CYC
) (
    // Clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_b_i,
    // Straps and analog status pins
    input  wire logic                  hs_capable_i,
    input  wire logic                  upstream_port_i,
    input  wire logic                  disc_det_i,
    // Requests and hub control
    input  wire hs_test_pkg::test_req_t req_i,
    input  wire logic                  hub_reset_i,
    // Receive side
    input  wire hs_test_pkg::token_t    token_i,
    input  wire hs_test_pkg::wire_bit_t up_rx_i,
    input  wire logic                  line_active_i,
    input  wire logic                  await_rsp_i,
    // Request answers and mode status
    output logic                       req_ack_o,
    output logic                       req_stall_o,
    output logic [7:0]                 mode_o,
    output logic                       mode_ready_o,
    // Line and port status
    output hs_test_pkg::line_drv_t     line_o,
    output logic                       port_enable_o,
    output logic                       disc_status_o,
    // Response window
    output logic                       rsp_timeout_o,
    output logic                       rsp_reply_o
);

    localparam logic [3:0] SETTLE_CYC = 4'(`SETTLE_CYC);
    localparam logic [5:0] NAK_LAST   = 6'(`NAK_PKT_BITS - 1);
    localparam logic [`NAK_PKT_BITS-1:0] NAK_WIRE = `NAK_PKT_WIRE;

    // Token CRC5 over address and endpoint, returned in wire order
    function automatic logic [4:0] token_crc5(input logic [10:0] d);
        logic [4:0] c;
        logic       fb;
        c = 5'h1F;
        for (int i = 0; i < 11; i++) begin
            fb = d[i] ^ c[4];
            c  = {c[3:0], 1'b0} ^ (fb ? 5'h05 : 5'h00);
        end
        return ~c;
    endfunction : token_crc5

    // Pins pass two flops; first stage feeds only the second
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {disc_det_i, upstream_port_i, hs_capable_i};
            pin_sync <= pin_meta;
        end
    end

    // Straps are caught once, after the synchroniser has filled
    logic [1:0] strap_wait;
    logic       straps_ok;
    logic       hs_cap;
    logic       is_upstream;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_wait  <= 2'h0;
            straps_ok   <= 1'b0;
            hs_cap      <= 1'b0;
            is_upstream <= 1'b0;
        end else if (!straps_ok) begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == 2'h3) begin
                straps_ok   <= 1'b1;
                hs_cap      <= pin_sync[0];
                is_upstream <= pin_sync[1];
            end
        end
    end

    hs_test_pkg::mode_state_t st;
    hs_test_pkg::mode_state_t next_st;
    logic [7:0] sel;
    logic [3:0] settle_cnt;

    // request kind must match the port
    wire kind_ok  = req_i.port_req == !is_upstream;
    // forced enable only on downstream ports
    wire sel_ok   = (req_i.selector >= `SEL_TEST_J && req_i.selector <= `SEL_PACKET)
                  || (req_i.selector == `SEL_FORCE_EN && !is_upstream);
    wire accept   = req_i.valid && straps_ok && hs_cap && kind_ok && sel_ok && st == hs_test_pkg::ST_IDLE;
    // hub reset leaves downstream modes only
    wire exit_req = hub_reset_i && !is_upstream;
    wire active   = st == hs_test_pkg::ST_ACTIVE;
    wire in_nak   = active && sel == `SEL_SE0_NAK;
    wire in_j     = active && sel == `SEL_TEST_J;
    wire in_k     = active && sel == `SEL_TEST_K;
    wire in_pkt   = active && sel == `SEL_PACKET;
    wire in_force = active && sel == `SEL_FORCE_EN;

    // Mode sequencing; once active, only the exit action leaves
    always_comb begin
        next_st = st;
        case (st)
            hs_test_pkg::ST_IDLE: begin
                if (accept) begin
                    next_st = hs_test_pkg::ST_SETTLE;
                end
            end
            hs_test_pkg::ST_SETTLE: begin
                if (settle_cnt == SETTLE_CYC - 4'h1) begin
                    next_st = hs_test_pkg::ST_ACTIVE;
                end
            end
            hs_test_pkg::ST_ACTIVE: begin
                next_st = hs_test_pkg::ST_ACTIVE;
            end
            default: begin
                next_st = hs_test_pkg::ST_IDLE;
            end
        endcase
        if (exit_req) begin
            next_st = hs_test_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st         <= hs_test_pkg::ST_IDLE;
            sel        <= `SEL_NONE;
            settle_cnt <= 4'h0;
        end else begin
            st         <= next_st;
            settle_cnt <= (st == hs_test_pkg::ST_SETTLE) ? settle_cnt + 4'h1 : 4'h0;
            if (exit_req) begin
                sel <= `SEL_NONE;
            end else if (accept) begin
                sel <= req_i.selector;
            end
        end
    end

    // Request answers; a request while a mode is latched is stalled
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_ack_o   <= 1'b0;
            req_stall_o <= 1'b0;
        end else begin
            req_ack_o   <= accept && !exit_req;
            req_stall_o <= req_i.valid && !(accept && !exit_req);
        end
    end

    // good IN token on upstream port
    wire token_ok = in_nak && is_upstream && token_i.valid && token_i.pid == `PID_IN
                  && token_crc5({token_i.endp, token_i.addr}) == token_i.crc5;

    logic       nak_busy;
    logic [5:0] nak_idx;

    // reply reaches the line two cycles after token
    // A token seen during a NAK already in flight is dropped; the host retries
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nak_busy <= 1'b0;
            nak_idx  <= 6'h00;
        end else if (!in_nak) begin
            nak_busy <= 1'b0;
            nak_idx  <= 6'h00;
        end else if (token_ok && !nak_busy) begin
            nak_busy <= 1'b1;
            nak_idx  <= 6'h00;
        end else if (nak_busy) begin
            nak_busy <= nak_idx != NAK_LAST;
            nak_idx  <= nak_idx + 6'h01;
        end
    end

    logic pkt_bit;
    logic pkt_en;
    logic pkt_start;

    test_pkt_gen u_pkt_gen (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .run_i     (in_pkt),
        .bit_o     (pkt_bit),
        .en_o      (pkt_en),
        .start_o   (pkt_start)
    );

    rsp_timeout u_rsp_timeout (
        .sys_clk_i     (sys_clk_i),
        .rst_b_i       (rst_b_i),
        .await_i       (await_rsp_i),
        .line_active_i (line_active_i),
        .timeout_o     (rsp_timeout_o),
        .reply_o       (rsp_reply_o)
    );

    hs_test_pkg::line_drv_t next_line;

    // Transceiver command for the latched mode; idle leaves the line alone
    always_comb begin
        next_line = '0;
        if (in_nak) begin
            next_line.hs_rx  = 1'b1;
            next_line.tx_en  = nak_busy;
            next_line.tx_bit = nak_busy & NAK_WIRE[NAK_LAST - nak_idx];
        end
        if (in_j) begin
            next_line.drive_j = 1'b1;
        end
        if (in_k) begin
            next_line.drive_k = 1'b1;
        end
        if (in_pkt) begin
            next_line.tx_en  = pkt_en;
            next_line.tx_bit = pkt_bit;
        end
        if (in_force) begin
            next_line.tx_en  = up_rx_i.active;
            next_line.tx_bit = up_rx_i.active & up_rx_i.data;
        end
    end

    // All outputs registered
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            line_o        <= '0;
            mode_o        <= `SEL_NONE;
            mode_ready_o  <= 1'b0;
            port_enable_o <= 1'b0;
            disc_status_o <= 1'b0;
        end else begin
            line_o        <= next_line;
            mode_o        <= sel;
            mode_ready_o  <= active;
            port_enable_o <= in_force;
            disc_status_o <= pin_sync[2];
        end
    end

    // Helper: cycles from acceptance to the mode being in force
    logic [15:0] entry_cnt;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            entry_cnt <= 16'h0000;
        end else begin
            entry_cnt <= (st == hs_test_pkg::ST_SETTLE) ? entry_cnt + 16'h0001 : 16'h0000;
        end
    end

    localparam int NAK_LO = `MIN_IPG_CYC;
    localparam int NAK_HI = `RSP_MAX_IPG_CYC;

    a_nak_reply: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (token_ok && !nak_busy && !exit_req) |-> ##[NAK_LO:NAK_HI] line_o.tx_en)
        else $error("NAK not started within reply gap");

    a_nak_gap: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (token_ok && !nak_busy) |=> !line_o.tx_en)
        else $error("NAK sent without minimum gap");

    a_entry_limit: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (st == hs_test_pkg::ST_SETTLE) |-> int'(entry_cnt) < ENTRY_MAX_CYC)
        else $error("test mode entry too slow");

    a_refuse_fs: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (req_i.valid && !hs_cap) |=> req_stall_o && !req_ack_o ##1 st == hs_test_pkg::ST_IDLE)
        else $error("entry accepted without high-speed");

    a_upstream_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (active && is_upstream) |=> active && $stable(sel))
        else $error("upstream test mode left without power cycle");

    a_hub_reset_exit: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (exit_req && st != hs_test_pkg::ST_IDLE) |=> st == hs_test_pkg::ST_IDLE ##1 mode_o == `SEL_NONE)
        else $error("hub reset did not leave test mode");

    a_force_down: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        port_enable_o |-> !is_upstream && mode_o == `SEL_FORCE_EN)
        else $error("forced enable on upstream port");

    a_j_held: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        in_j |=> line_o.drive_j && !line_o.drive_k && !line_o.tx_en)
        else $error("J state not held");

    a_k_held: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        in_k |=> line_o.drive_k && !line_o.drive_j && !line_o.tx_en)
        else $error("K state not held");

    a_rx_held: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        in_nak |=> line_o.hs_rx && !line_o.drive_j && !line_o.drive_k)
        else $error("receive mode not held");

    a_repeat_up: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (in_force && up_rx_i.active) |=> line_o.tx_en && line_o.tx_bit == $past(up_rx_i.data))
        else $error("upstream packet not repeated");

    a_pkt_restart: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (in_pkt && pkt_start) |=> line_o.tx_en == 1'b0 ##1 line_o.tx_en)
        else $error("test packet not restarted");

    a_one_mode: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $onehot0({in_nak, in_j, in_k, in_pkt, in_force}) && (!active || sel != `SEL_NONE))
        else $error("more than one test behaviour");

    a_disc_live: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        in_force |=> disc_status_o == $past(pin_sync[2]))
        else $error("disconnect status not live");

endmodule : hs_test_mode_ctrl

// file: verilog/rsp_timeout.sv
`timescale 1ns/100ps
`include "hs_test_regs.svh"

module rsp_timeout (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    // Wait control
    input  wire logic await_i,
    input  wire logic line_active_i,
    // Outcome
    output logic      timeout_o,
    output logic      reply_o
);

    localparam logic [4:0] KEEP_CYC    = 5'(`RSP_KEEP_CYC);
    localparam logic [4:0] ABANDON_CYC = 5'(`RSP_ABANDON_CYC);

    logic       run;
    logic [4:0] cnt;

    wire last_cycle = run && !line_active_i && (cnt == ABANDON_CYC - 5'h01);

    // Counter restarts on every new wait; signalling ends the wait at once
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run       <= 1'b0;
            cnt       <= 5'h00;
            timeout_o <= 1'b0;
            reply_o   <= 1'b0;
        end else begin
            timeout_o <= last_cycle && !await_i;
            reply_o   <= run && line_active_i && !await_i;
            if (await_i) begin
                run <= 1'b1;
                cnt <= 5'h00;
            end else if (run && (line_active_i || last_cycle)) begin
                run <= 1'b0;
            end else if (run) begin
                cnt <= cnt + 5'h01;
            end
        end
    end

    a_keep_alive: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(timeout_o) |-> $past(cnt) >= KEEP_CYC - 5'h01)
        else $error("response wait abandoned too early");

    a_abandon_bound: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (last_cycle && !await_i) |=> timeout_o && !run)
        else $error("response wait not abandoned at limit");

endmodule : rsp_timeout

// file: verilog/test_pkt_gen.sv
`timescale 1ns/100ps
`include "hs_test_regs.svh"

module test_pkt_gen (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    // Control
    input  wire logic run_i,
    // Wire bit stream
    output logic      bit_o,
    output logic      en_o,
    output logic      start_o
);

    // packet by concatenation
    // Stuff bits are emitted as zeros, so the transceiver stuffer stays off
    localparam logic [`TEST_PKT_BITS-1:0] PKT = {
        {3{8'h00}}, 8'h01,                      // SYNC
        8'hC3,                                  // DATA0 PID
        {9{8'h00}},
        {8{8'h55}},
        {8{8'h77}},
        1'h0, {15{7'h7E}}, 6'h3F,
        1'h0, 7'h7E, {7{8'h7E}},
        8'h3F, {9{8'h3F}}, 2'h0,
        16'h6D73,                               // CRC16
        8'h7F                                   // EOP
    };
    localparam logic [9:0] LAST_BIT = 10'(`TEST_PKT_BITS - 1);
    localparam logic [9:0] GAP_CYC  = 10'(`PKT_GAP_CYC);

    logic       sending;
    logic [9:0] idx;

    wire pkt_end = sending && (idx == LAST_BIT);
    wire gap_end = !sending && (idx == GAP_CYC - 10'h001);

    // endless repetition
    // Index walks the packet, then is reused to time the gap
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sending <= 1'b0;
            idx     <= 10'h000;
            bit_o   <= 1'b0;
            en_o    <= 1'b0;
            start_o <= 1'b0;
        end else if (!run_i) begin
            sending <= 1'b0;
            idx     <= 10'h000;
            bit_o   <= 1'b0;
            en_o    <= 1'b0;
            start_o <= 1'b0;
        end else begin
            en_o    <= sending;
            bit_o   <= sending ? PKT[LAST_BIT - idx] : 1'b0;
            start_o <= gap_end;
            if (pkt_end || gap_end) begin
                sending <= !sending;
                idx     <= 10'h000;
            end else begin
                idx <= idx + 10'h001;
            end
        end
    end

    a_gap_window: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (run_i && $fell(en_o)) |-> !en_o ##[1:1000] (en_o || !run_i))
        else $error("test packet gap out of range");

    a_sync_first: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (run_i && sending && idx == 10'h01F) |=> bit_o && en_o)
        else $error("sync pattern does not end in one");

endmodule : test_pkt_gen
